// ===== pkg/swc_pkg.sv
// constants and carrier types for the sweep and modulator configuration register bank
//
// Summary of operation
// - upper ramp step count: 30-bit read/write field, reset zero
// - lower ramp step count: 18-bit read/write field, reset zero
// - symmetric sweep: count serves up and down ramps; asymmetric: up only
// - stage one accumulator width code: 00=48, 01=32, 10=24, 11=16 bits; reset 48
// - stage two accumulator width uses the same code; reset 48 bits
// - stage three accumulator width uses the same code; reset 48 bits
// - three bits stop fractional accumulator clocks when one; reset zero
// - three bits stop integer accumulator clocks when one; reset zero
// - mode A clock stops when its bit is one; reset zero
// - mode B clock stops when its bit is one; reset zero
// - integer path clock stops when its bit is one; reset zero
// - input buffer clock stops when its bit is one; reset zero
// - output buffer clock stops when its bit is one; reset zero
// - upper downward ramp step size: 30-bit read/write, reset zero, ramp mode
// - lower downward ramp step size: 18-bit read/write, reset zero
// - index 17h holds no register and no storage
`default_nettype none

package swc_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W = 10;

	// ****************************************************************
	// register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [IDX_W-1:0] IDX_STEP_COUNT_HIGH = 10'h014;
	localparam logic [IDX_W-1:0] IDX_STEP_COUNT_LOW = 10'h015;
	localparam logic [IDX_W-1:0] IDX_MODULATOR_CONFIG = 10'h016;
	localparam logic [IDX_W-1:0] IDX_ABSENT = 10'h017;
	localparam logic [IDX_W-1:0] IDX_DOWN_STEP_HIGH = 10'h019;
	localparam logic [IDX_W-1:0] IDX_DOWN_STEP_LOW = 10'h01a;

	// ****************************************************************
	// field widths and positions
	// ****************************************************************
	localparam int unsigned HIGH_W = 30;
	localparam int unsigned LOW_W = 18;
	localparam int unsigned FULL_W = 48;
	localparam int unsigned CFG_W = 20;
	localparam int unsigned ACC1_LSB = 0;
	localparam int unsigned ACC2_LSB = 2;
	localparam int unsigned ACC3_LSB = 4;
	localparam int unsigned FRAC_OFF_LSB = 6;
	localparam int unsigned INT_OFF_LSB = 9;
	localparam int unsigned MODE_A_OFF_BIT = 12;
	localparam int unsigned MODE_B_OFF_BIT = 13;
	localparam int unsigned INT_PATH_OFF_BIT = 15;
	localparam int unsigned IN_BUF_OFF_BIT = 16;
	localparam int unsigned OUT_BUF_OFF_BIT = 17;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [HIGH_W-1:0] RST_HIGH = 30'h0000_0000;
	localparam logic [LOW_W-1:0] RST_LOW = 18'h0_0000;
	localparam logic [CFG_W-1:0] RST_CFG = 20'h0_0000;

	// ****************************************************************
	// accumulator width codes and their sizes in bits
	// ****************************************************************
	typedef enum logic [1:0] {
		ACC_48 = 2'h0,
		ACC_32 = 2'h1,
		ACC_24 = 2'h2,
		ACC_16 = 2'h3
	} swc_acc_e;
	localparam logic [5:0] BITS_48 = 6'h30;
	localparam logic [5:0] BITS_32 = 6'h20;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [5:0] BITS_16 = 6'h10;

	// ****************************************************************
	// carriers
	// ****************************************************************
	// clock stop controls, one means the clock is held
	typedef struct packed {
		logic [2:0] frac_off;
		logic [2:0] int_off;
		logic mode_a_off;
		logic mode_b_off;
		logic int_path_off;
		logic in_buf_off;
		logic out_buf_off;
	} swc_gate_s;

	// per-stage accumulator width, code and decoded size
	typedef struct packed {
		swc_acc_e [2:0] code;
		logic [2:0][5:0] bits;
	} swc_acc_s;

	// whole module state
	typedef struct packed {
		logic [HIGH_W-1:0] step_hi;
		logic [LOW_W-1:0] step_lo;
		logic [CFG_W-1:0] cfg;
		logic [HIGH_W-1:0] down_hi;
		logic [LOW_W-1:0] down_lo;
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic [FULL_W-1:0] up_count;
		logic [FULL_W-1:0] down_count;
		logic down_count_used;
		logic [FULL_W-1:0] down_size;
		swc_acc_s acc;
		swc_gate_s gate;
	} swc_state_s;

endpackage : swc_pkg

`default_nettype wire

// ===== rtl/swc_cfg_regs.sv
// sweep step count, down step size and modulator configuration register bank on apb
`timescale 1ns/1ps
`default_nettype none

module swc_cfg_regs (
	// clock and synchronous reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [swc_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [swc_pkg::DATA_W-1:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [swc_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// sweep engine side
	input wire logic asym_sweep_in,
	output logic [swc_pkg::FULL_W-1:0] up_step_count_out,
	output logic [swc_pkg::FULL_W-1:0] down_step_count_out,
	output logic down_step_count_used_out,
	output logic [swc_pkg::FULL_W-1:0] down_step_size_out,
	// sigma_delta_core side
	output swc_pkg::swc_acc_s acc_width_out,
	output swc_pkg::swc_gate_s clk_gate_out
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// code to accumulator size in bits
	function automatic logic [5:0] acc_bits(input swc_pkg::swc_acc_e code);
		logic [5:0] b;
		b = swc_pkg::BITS_48;
		unique case (code)
			swc_pkg::ACC_48: b = swc_pkg::BITS_48;
			swc_pkg::ACC_32: b = swc_pkg::BITS_32;
			swc_pkg::ACC_24: b = swc_pkg::BITS_24;
			swc_pkg::ACC_16: b = swc_pkg::BITS_16;
		endcase
		return b;
	endfunction : acc_bits

	// byte-lane merge of write data over an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : merge

	// ****************************************************************
	// state
	// ****************************************************************
	swc_pkg::swc_state_s q;
	swc_pkg::swc_state_s d;

	logic [swc_pkg::IDX_W-1:0] idx;
	logic hit;
	logic setup;
	logic wr_go;
	logic [31:0] rd_word;
	logic [31:0] old_word;
	logic [31:0] new_word;

	// word index; low two address bits are ignored
	assign idx = paddr_in[swc_pkg::ADDR_W-1:2];
	assign setup = psel_in & ~penable_in;
	// a write lands only at the completing access edge
	assign wr_go = psel_in & penable_in & q.pready & pwrite_in;

	// ****************************************************************
	// address decode and read mux
	// ****************************************************************
	// index 17h and every other hole decode as a miss
	always_comb begin
		hit = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (idx)
			swc_pkg::IDX_STEP_COUNT_HIGH: rd_word = {2'h0, q.step_hi};
			swc_pkg::IDX_STEP_COUNT_LOW: rd_word = {14'h0000, q.step_lo};
			swc_pkg::IDX_MODULATOR_CONFIG: rd_word = {12'h000, q.cfg};
			swc_pkg::IDX_DOWN_STEP_HIGH: rd_word = {2'h0, q.down_hi};
			swc_pkg::IDX_DOWN_STEP_LOW: rd_word = {14'h0000, q.down_lo};
			default: hit = 1'b0;
		endcase
	end

	// old contents used for byte-lane merging (same word as the read view)
	assign old_word = rd_word;
	assign new_word = merge(old_word, pwdata_in, pstrb_in);

	// ****************************************************************
	// next state
	// ****************************************************************
	// one zero-wait answer: read data and error are captured in the setup
	// cycle so every bus output comes straight from a flip-flop
	always_comb begin
		d = q;
		d.pready = setup;
		if (setup) begin
			d.prdata = pwrite_in ? 32'h0000_0000 : rd_word;
			d.pslverr = ~hit;
		end else if (psel_in & penable_in & q.pready) begin
			d.prdata = 32'h0000_0000;
			d.pslverr = 1'b0;
		end
		// register writes; misses store nothing
		if (wr_go & hit) begin
			unique case (idx)
				swc_pkg::IDX_STEP_COUNT_HIGH: d.step_hi = new_word[swc_pkg::HIGH_W-1:0];
				swc_pkg::IDX_STEP_COUNT_LOW: d.step_lo = new_word[swc_pkg::LOW_W-1:0];
				// reserved bits are stored and read back but steer nothing
				swc_pkg::IDX_MODULATOR_CONFIG: d.cfg = new_word[swc_pkg::CFG_W-1:0];
				swc_pkg::IDX_DOWN_STEP_HIGH: d.down_hi = new_word[swc_pkg::HIGH_W-1:0];
				swc_pkg::IDX_DOWN_STEP_LOW: d.down_lo = new_word[swc_pkg::LOW_W-1:0];
				default: d.cfg = q.cfg;
			endcase
		end
		// joined 48-bit values, 30-bit upper field on top
		d.up_count = {d.step_hi, d.step_lo};
		d.down_size = {d.down_hi, d.down_lo};
		// the count governs the down ramp only while the sweep is symmetric
		d.down_count_used = ~asym_sweep_in;
		d.down_count = asym_sweep_in ? {swc_pkg::FULL_W{1'b0}} : {d.step_hi, d.step_lo};
		// accumulator widths per stage
		d.acc.code[0] = swc_pkg::swc_acc_e'(d.cfg[swc_pkg::ACC1_LSB +: 2]);
		d.acc.code[1] = swc_pkg::swc_acc_e'(d.cfg[swc_pkg::ACC2_LSB +: 2]);
		d.acc.code[2] = swc_pkg::swc_acc_e'(d.cfg[swc_pkg::ACC3_LSB +: 2]);
		d.acc.bits[0] = acc_bits(d.acc.code[0]);
		d.acc.bits[1] = acc_bits(d.acc.code[1]);
		d.acc.bits[2] = acc_bits(d.acc.code[2]);
		// clock stops, a one holds the clock
		d.gate.frac_off = d.cfg[swc_pkg::FRAC_OFF_LSB +: 3];
		d.gate.int_off = d.cfg[swc_pkg::INT_OFF_LSB +: 3];
		d.gate.mode_a_off = d.cfg[swc_pkg::MODE_A_OFF_BIT];
		d.gate.mode_b_off = d.cfg[swc_pkg::MODE_B_OFF_BIT];
		d.gate.int_path_off = d.cfg[swc_pkg::INT_PATH_OFF_BIT];
		d.gate.in_buf_off = d.cfg[swc_pkg::IN_BUF_OFF_BIT];
		d.gate.out_buf_off = d.cfg[swc_pkg::OUT_BUF_OFF_BIT];
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// all-zero reset gives 48-bit accumulators and every clock running
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata_out = q.prdata;
	assign pready_out = q.pready;
	assign pslverr_out = q.pslverr;
	assign up_step_count_out = q.up_count;
	assign down_step_count_out = q.down_count;
	assign down_step_count_used_out = q.down_count_used;
	assign down_step_size_out = q.down_size;
	assign acc_width_out = q.acc;
	assign clk_gate_out = q.gate;

endmodule : swc_cfg_regs

`default_nettype wire

// ===== test/swc_cfg_regs_props.sv
// assertions on the ports of the sweep and modulator register bank
`timescale 1ns/1ps
`default_nettype none
module swc_cfg_regs_props (
	// clock, reset and bus
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// derived outputs
	input wire logic asym_sweep_in,
	input wire logic [47:0] up_step_count_out,
	input wire logic [47:0] down_step_count_out,
	input wire logic down_step_count_used_out,
	input wire logic [47:0] down_step_size_out,
	input wire swc_pkg::swc_acc_s acc_width_out,
	input wire swc_pkg::swc_gate_s clk_gate_out
);
	// ****************************************************************
	// helpers: full-word write completing, data and mode one cycle back
	// ****************************************************************
	wire [9:0] idx = paddr_in[11:2];
	wire wr_done = psel_in && penable_in && pready_out && pwrite_in && pstrb_in == 4'hf;
	logic [31:0] wd_q;
	logic asym_q;
	always_ff @(posedge clk_sys_in) begin
		wd_q <= pwdata_in;
		asym_q <= asym_sweep_in;
	end
	function automatic logic [5:0] bsz(input logic [1:0] c);
		return c == 2'h0 ? 6'h30 : c == 2'h1 ? 6'h20 : c == 2'h2 ? 6'h18 : 6'h10;
	endfunction : bsz
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	chk_ready_next: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	chk_absent_err: assert property (psel_in && !penable_in && idx == swc_pkg::IDX_ABSENT
		|=> pslverr_out && prdata_out == 32'h0) else $error("absent index answered");
	chk_step_low: assert property (wr_done && idx == swc_pkg::IDX_STEP_COUNT_LOW
		|=> up_step_count_out[17:0] == wd_q[17:0]) else $error("low count lost");
	chk_step_high: assert property (wr_done && idx == swc_pkg::IDX_STEP_COUNT_HIGH
		|=> up_step_count_out[47:18] == wd_q[29:0]) else $error("high count lost");
	chk_down_low: assert property (wr_done && idx == swc_pkg::IDX_DOWN_STEP_LOW
		|=> down_step_size_out[17:0] == wd_q[17:0]) else $error("low size lost");
	chk_down_high: assert property (wr_done && idx == swc_pkg::IDX_DOWN_STEP_HIGH
		|=> down_step_size_out[47:18] == wd_q[29:0]) else $error("high size lost");
	chk_cfg_map: assert property (wr_done && idx == swc_pkg::IDX_MODULATOR_CONFIG
		|=> acc_width_out.code == wd_q[5:0] && clk_gate_out == {wd_q[8:6], wd_q[11:9],
		wd_q[12], wd_q[13], wd_q[15], wd_q[16], wd_q[17]}) else $error("config fields misplaced");
	chk_used_mode: assert property ($past(rst_n_in)
		|-> down_step_count_used_out == !asym_q) else $error("down use flag wrong");
	chk_down_count: assert property (down_step_count_out ==
		(down_step_count_used_out ? up_step_count_out : 48'h0)) else $error("down count wrong");
	chk_acc_bits: assert property ($past(rst_n_in) |->
		acc_width_out.bits[0] == bsz(acc_width_out.code[0]) &&
		acc_width_out.bits[1] == bsz(acc_width_out.code[1]) &&
		acc_width_out.bits[2] == bsz(acc_width_out.code[2])) else $error("width decode wrong");
	cov_cfg: cover property (wr_done && idx == swc_pkg::IDX_MODULATOR_CONFIG);
	cov_err: cover property (pslverr_out);
	cov_asym: cover property (!down_step_count_used_out);
endmodule : swc_cfg_regs_props
bind swc_cfg_regs swc_cfg_regs_props swc_cfg_regs_props_inst (
	.clk_sys_in(clk_sys_in),
	.rst_n_in(rst_n_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pwrite_in(pwrite_in),
	.paddr_in(paddr_in),
	.pwdata_in(pwdata_in),
	.pstrb_in(pstrb_in),
	.prdata_out(prdata_out),
	.pready_out(pready_out),
	.pslverr_out(pslverr_out),
	.asym_sweep_in(asym_sweep_in),
	.up_step_count_out(up_step_count_out),
	.down_step_count_out(down_step_count_out),
	.down_step_count_used_out(down_step_count_used_out),
	.down_step_size_out(down_step_size_out),
	.acc_width_out(acc_width_out),
	.clk_gate_out(clk_gate_out)
);
`default_nettype wire

// ===== test/test_swc_cfg_regs.sv
// self-checking bench for the sweep and modulator register bank
`timescale 1ns/1ps
`default_nettype none
module test_swc_cfg_regs;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic asym_sweep_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0;
	logic [3:0] pstrb_in = 4'hf;
	logic [31:0] prdata_out, rd, d;
	logic pready_out, pslverr_out, down_step_count_used_out, er;
	logic [47:0] up_step_count_out, down_step_count_out, down_step_size_out;
	swc_pkg::swc_acc_s acc_width_out;
	swc_pkg::swc_gate_s clk_gate_out;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int i;
	logic [31:0] rng = 32'd39801;
	logic [31:0] sh [5];
	logic [9:0] ix [5] = '{10'h014, 10'h015, 10'h016, 10'h019, 10'h01a};
	logic [31:0] msk [5] = '{32'h3fffffff, 32'h3ffff, 32'hfffff, 32'h3fffffff, 32'h3ffff};
	swc_cfg_regs swc_cfg_regs_inst (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.pstrb_in(pstrb_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.asym_sweep_in(asym_sweep_in),
		.up_step_count_out(up_step_count_out),
		.down_step_count_out(down_step_count_out),
		.down_step_count_used_out(down_step_count_used_out),
		.down_step_size_out(down_step_size_out),
		.acc_width_out(acc_width_out),
		.clk_gate_out(clk_gate_out)
	);
	// ****************************************************************
	// clock, timeout, helpers
	// ****************************************************************
	initial forever #2 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	function automatic logic [5:0] bsz(input logic [1:0] c);
		return c == 2'h0 ? 6'h30 : c == 2'h1 ? 6'h20 : c == 2'h2 ? 6'h18 : 6'h10;
	endfunction : bsz
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	// one edge of idle first, so a strobe is never driven twice in one step
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] v,
		input logic [3:0] s);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= {a, 2'h0};
		pwdata_in <= v;
		pstrb_in <= s;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		// wait for the answer; only the bench timeout ends a hang
		do begin
			@(posedge clk_sys_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic wr(input int k, input logic [31:0] v, input logic [3:0] s);
		apb(1'b1, ix[k], v, s);
		for (int b = 0; b < 4; b++) if (s[b]) sh[k][8*b +: 8] = v[8*b +: 8];
		sh[k] &= msk[k];
	endtask : wr
	// derived outputs, a moment after the storing edge
	task automatic outs();
		#1;
		check(up_step_count_out, {sh[0][29:0], sh[1][17:0]});
		check(down_step_size_out, {sh[3][29:0], sh[4][17:0]});
		check(down_step_count_out, asym_sweep_in ? 48'h0 : {sh[0][29:0], sh[1][17:0]});
		check(down_step_count_used_out, !asym_sweep_in);
		check(clk_gate_out, {sh[2][8:6], sh[2][11:9], sh[2][12], sh[2][13], sh[2][15],
			sh[2][16], sh[2][17]});
		check(acc_width_out.code, sh[2][5:0]);
		for (int k = 0; k < 3; k++) check(acc_width_out.bits[k], bsz(sh[2][2*k +: 2]));
	endtask : outs
	task automatic rdall();
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, ix[k], 32'h0, 4'hf);
			check(rd, sh[k]);
			check(er, 1'b0);
		end
	endtask : rdall
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		for (int k = 0; k < 5; k++) sh[k] = 32'h0;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rdall();
		outs();
		$display("reset values done");
		// every width code in every stage, gate bits random
		for (int c = 0; c < 4; c++) begin
			d = xs();
			wr(2, {d[31:6], c[1:0], c[1:0], c[1:0]}, 4'hf);
			outs();
		end
		$display("width codes done");
		// random traffic, partial strobes late in the run, mode flips between
		for (int t = 0; t < 40; t++) begin
			d = xs();
			i = d[2:0] % 5;
			d = xs();
			wr(i, d, t < 28 ? 4'hf : rng[11:8]);
			outs();
			apb(1'b0, ix[i], 32'h0, 4'hf);
			check(rd, sh[i]);
			asym_sweep_in <= rng[20];
		end
		$display("random traffic done");
		// reset in mid-run: every register must fall back to zero
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		for (int k = 0; k < 5; k++) sh[k] = 32'h0;
		rdall();
		outs();
		$display("mid-run reset done");
		// the missing index and a far unmapped one: refused, nothing stored
		apb(1'b1, swc_pkg::IDX_ABSENT, 32'hffffffff, 4'hf);
		check(er, 1'b1);
		apb(1'b0, swc_pkg::IDX_ABSENT, 32'h0, 4'hf);
		check({er, rd}, {1'b1, 32'h0});
		apb(1'b0, 10'h3ff, 32'h0, 4'hf);
		check(er, 1'b1);
		rdall();
		$display("unmapped access done");
		wrap_up();
	end
endmodule : test_swc_cfg_regs
`default_nettype wire
